/* File: cvr_ctrl.sv */
// Comparator result, polarity, pin routing and reference ladder control.
// Assumes one clock mclk, synchronous reset rst, AHB-Lite single master.
`timescale 1ns/1ps
`include "cvr_defines.svh"

module cvr_ctrl (
  input wire logic mclk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Raw comparator decisions from the analog side
  input wire logic cmp1_raw,
  input wire logic cmp2_raw,
  // Port A pins, bits 4 and 5 can carry comparators
  input wire logic [5:0] pa_in,
  output logic [5:0] pa_out,
  output logic [5:0] pa_oe_n,
  // Analog controls
  output logic [2:0] comparator_mode_field,
  output logic ladder_ref_sel,
  output logic ladder_power_on,
  output logic ladder_pin_drive,
  output logic ladder_range_sel,
  output logic [3:0] ladder_tap_value
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------

  // Word index from a byte address
  function automatic logic [7:0] idx_of(
    input logic [31:0] a
  );
    idx_of = a[9:2];
  endfunction : idx_of

  // Known register index check
  function automatic logic idx_hit(
    input logic [7:0] i
  );
    idx_hit = (i == `CVR_IDX_PORT) ||
              (i == `CVR_IDX_DIR) ||
              (i == `CVR_IDX_CMCFG) ||
              (i == `CVR_IDX_LADDER) ||
              (i == `CVR_IDX_ANSEL) ||
              (i == `CVR_IDX_ROUTE);
  endfunction : idx_hit

  // ----------------------------------------
  // State
  // ----------------------------------------
  cvr_pkg::cvr_bus_st_t st_r;
  cvr_pkg::cvr_bus_st_t st_nxt;
  logic [7:0] aidx_r;
  logic [7:0] aidx_nxt;
  logic hready_r;
  logic hready_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;

  logic [7:0] cmcfg_r;
  logic [7:0] cmcfg_nxt;
  logic [7:0] ladder_r;
  logic [7:0] ladder_nxt;
  logic [5:0] dir_r;
  logic [5:0] dir_nxt;
  logic [5:0] ansel_r;
  logic [5:0] ansel_nxt;
  logic [5:0] port_r;
  logic [5:0] port_nxt;
  logic route_r;
  logic route_nxt;
  logic refsel_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------

  // Transfer taken only while the bus is ready
  wire accept = hsel && htrans[1] && hready;
  wire wr_now = (st_r == cvr_pkg::ST_WR);
  wire rd_now = (st_r == cvr_pkg::ST_RD);
  wire [7:0] wdat = hwdata[7:0];
  wire we_cmcfg = wr_now && (aidx_r == `CVR_IDX_CMCFG);
  wire we_ladder = wr_now && (aidx_r == `CVR_IDX_LADDER);
  wire we_dir = wr_now && (aidx_r == `CVR_IDX_DIR);
  wire we_ansel = wr_now && (aidx_r == `CVR_IDX_ANSEL);
  wire we_port = wr_now && (aidx_r == `CVR_IDX_PORT);
  wire we_route = wr_now && (aidx_r == `CVR_IDX_ROUTE);

  // Next bus phase; a read holds one wait state before the answer
  always_comb begin
    case (st_r)
      cvr_pkg::ST_RD: begin
        st_nxt = cvr_pkg::ST_RDY;
      end
      default: begin
        st_nxt = cvr_pkg::ST_IDLE;
      end
    endcase
    if (accept) begin
      st_nxt = hwrite ? cvr_pkg::ST_WR : cvr_pkg::ST_RD;
    end
  end
  assign aidx_nxt = accept ? idx_of(haddr) : aidx_r;
  assign hready_nxt = !(accept && !hwrite);

  // ----------------------------------------
  // Comparator view
  // ----------------------------------------

  // Polarity applied to both read and pin paths
  wire cmp1_v = cmp1_raw ^ cmcfg_r[`CVR_B_INV1]; // High when non-inverting input is above
  wire cmp2_v = cmp2_raw ^ cmcfg_r[`CVR_B_INV2];

  // Results never stored, so writes cannot touch them
  wire [7:0] cmcfg_rd = {cmp2_v, cmp1_v, cmcfg_r[5:0]};

  // Analog pins read as zero whatever the voltage
  wire [5:0] port_rd = pa_in & ~ansel_r;

  // Unimplemented ladder bit forced low on read
  wire [7:0] ladder_rd = ladder_r & `CVR_LADDER_WMASK;

  // Read mux; unmapped reads give zero
  wire [7:0] rd_byte =
    (aidx_r == `CVR_IDX_CMCFG) ? cmcfg_rd :
    (aidx_r == `CVR_IDX_LADDER) ? ladder_rd :
    (aidx_r == `CVR_IDX_PORT) ? {2'h0, port_rd} :
    (aidx_r == `CVR_IDX_DIR) ? {2'h0, dir_r} :
    (aidx_r == `CVR_IDX_ANSEL) ? {2'h0, ansel_r} :
    (aidx_r == `CVR_IDX_ROUTE) ? {7'h00, route_r} : 8'h00;
  wire mapped = idx_hit(aidx_r);
  assign hrdata_nxt = (rd_now && mapped) ? {24'h000000, rd_byte} :
                      rd_now ? 32'h00000000 : hrdata_r;

  // ----------------------------------------
  // Register next values
  // ----------------------------------------

  // Result bits masked out of the write
  assign cmcfg_nxt = we_cmcfg ?
    ((cmcfg_r & ~`CVR_CMCFG_WMASK) | (wdat & `CVR_CMCFG_WMASK)) :
    cmcfg_r;

  // Bit 4 dropped on write
  assign ladder_nxt = we_ladder ? (wdat & `CVR_LADDER_WMASK) : ladder_r;
  assign dir_nxt = we_dir ? wdat[5:0] : dir_r;
  assign ansel_nxt = we_ansel ? wdat[5:0] : ansel_r;
  assign port_nxt = we_port ? wdat[5:0] : port_r;
  assign route_nxt = we_route ? wdat[0] : route_r;

  // ----------------------------------------
  // Bus flops
  // ----------------------------------------

  // Slave phase tracking
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= cvr_pkg::ST_IDLE;
      aidx_r <= 8'h00;
      hready_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      aidx_r <= aidx_nxt;
      hready_r <= hready_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ----------------------------------------
  // Control flops
  // ----------------------------------------

  // Stored fields change only on a write edge or a reset edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmcfg_r <= `CVR_CMCFG_RST;
      ladder_r <= `CVR_LADDER_RST;
      dir_r <= `CVR_DIR_RST;
      ansel_r <= `CVR_ANSEL_RST;
      port_r <= `CVR_PORT_RST;
      route_r <= 1'b0;
    end else begin
      cmcfg_r <= cmcfg_nxt;
      ladder_r <= ladder_nxt;
      dir_r <= dir_nxt;
      ansel_r <= ansel_nxt;
      port_r <= port_nxt;
      route_r <= route_nxt;
    end
  end

  // Ladder feeds both non-inverting inputs in mode 110
  always_ff @(posedge mclk) begin
    if (rst) begin
      refsel_r <= 1'b0;
    end else begin
      refsel_r <= (cmcfg_nxt[2:0] == `CVR_MODE_REF);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Bus answer is always OKAY
  assign hreadyout = hready_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // Ladder power, pin, range and tap straight from flops
  assign ladder_power_on = ladder_r[`CVR_B_PWR];
  assign ladder_pin_drive = ladder_r[`CVR_B_PIN];
  assign ladder_range_sel = ladder_r[`CVR_B_RANGE];
  assign ladder_tap_value = ladder_r[3:0];
  assign comparator_mode_field = cmcfg_r[2:0];
  assign ladder_ref_sel = refsel_r;

  // Raw path bypasses the clock on purpose: no added latency
  assign pa_out = route_r ? {cmp2_v, cmp1_v, port_r[3:0]} : port_r;

  // Direction bit 0 drives the pin, also when routed
  assign pa_oe_n = dir_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  // Cycle marker for a completed register read
  logic rd_done;
  assign rd_done = (st_r == cvr_pkg::ST_RDY);

  // Accepted read answers two edges later
  sequence s_rd_take;
    accept && !hwrite;
  endsequence

  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_rd_wait;
    @(posedge mclk) disable iff (rst)
    s_rd_take |=> s_rd_ans;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read answer timing wrong");

  property p_result_ro;
    @(posedge mclk) disable iff (rst)
    (rd_now && aidx_r == `CVR_IDX_CMCFG) |=>
      hrdata[7:6] == $past({cmp2_raw ^ cmcfg_r[5], cmp1_raw ^ cmcfg_r[4]});
  endproperty
  a_result_ro: assert property (p_result_ro)
    else $error("comparator result read wrong");

  property p_raw_high;
    @(posedge mclk) disable iff (rst)
    (rd_now && aidx_r == `CVR_IDX_CMCFG && !cmcfg_r[`CVR_B_INV1]) |=>
      hrdata[`CVR_B_RES1] == $past(cmp1_raw);
  endproperty
  a_raw_high: assert property (p_raw_high)
    else $error("comparator result polarity wrong");

  property p_pin_route;
    @(posedge mclk) disable iff (rst)
    route_r |-> (pa_out[4] == (cmp1_raw ^ cmcfg_r[4])) &&
                (pa_out[5] == (cmp2_raw ^ cmcfg_r[5]));
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("routed pin not following comparator");

  property p_pin_dir;
    @(posedge mclk) disable iff (rst)
    we_dir |=> pa_oe_n[5:4] == $past(wdat[5:4]);
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("direction bits not enabling pins");

  property p_analog_zero;
    @(posedge mclk) disable iff (rst)
    (rd_now && aidx_r == `CVR_IDX_PORT) |=>
      (hrdata[5:0] & $past(ansel_r)) == 6'h00;
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog pin read nonzero");

  property p_ref_mode;
    @(posedge mclk) disable iff (rst)
    we_cmcfg |=> ladder_ref_sel == ($past(wdat[2:0]) == `CVR_MODE_REF);
  endproperty
  a_ref_mode: assert property (p_ref_mode)
    else $error("ladder reference select wrong");

  property p_ladder_wr;
    @(posedge mclk) disable iff (rst)
    we_ladder |=> ladder_power_on == $past(wdat[7]) &&
      ladder_pin_drive == $past(wdat[6]) &&
      ladder_range_sel == $past(wdat[5]) &&
      ladder_tap_value == $past(wdat[3:0]);
  endproperty
  a_ladder_wr: assert property (p_ladder_wr)
    else $error("ladder control not taken");

  property p_unimp_zero;
    @(posedge mclk) disable iff (rst)
    (rd_now && aidx_r == `CVR_IDX_LADDER) |=> hrdata[4] == 1'b0;
  endproperty
  a_unimp_zero: assert property (p_unimp_zero)
    else $error("ladder bit 4 read nonzero");

  property p_tap_hold;
    @(posedge mclk) disable iff (rst)
    (!we_ladder && !rst) |=> $stable(ladder_tap_value) && $stable(ladder_range_sel);
  endproperty
  a_tap_hold: assert property (p_tap_hold)
    else $error("tap or range moved without write");

  property p_rd_hold;
    @(posedge mclk) disable iff (rst)
    rd_done ##1 !rd_now |-> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed while idle");

  property p_rst_vals;
    @(posedge mclk)
    rst |=> hreadyout && (hrdata == 32'h00000000) && (pa_oe_n == `CVR_DIR_RST) &&
      !ladder_ref_sel && (ladder_tap_value == 4'h0) && !ladder_power_on;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset values");

  property p_wr_no_wait;
    @(posedge mclk) disable iff (rst)
    (accept && hwrite) |=> hreadyout;
  endproperty
  a_wr_no_wait: assert property (p_wr_no_wait)
    else $error("write data phase stalled");

endmodule : cvr_ctrl

/* File: cvr_defines.svh */
// Constants for the comparator and reference ladder control block.
// Assumes a 32-bit AHB-Lite slave port; byte address is 4 x index.
//
// What this block does
// - Comparator result bits are read-only in the comparator config register.
// - Pin routing on: pins 4 and 5 driven by the comparator outputs after polarity.
// - Port A direction bits still enable the routed pins.
// - Bits 4 and 5 invert each comparator as read and driven.
// - Port reads return 0 for analog-configured pins.
// - Ladder is the comparator reference only in mode 110.
// - Ladder control bit 6 connects the level to the shared pin.
// - Bit 5 picks range: 0..2/3 step 1/24, or 1/4..3/4 step 1/32.
// - Bits 3..0 are the tap value 0 to 15.
// - Ladder control bit 4 reads zero and ignores writes.
// - In mode 110 the reference feeds both non-inverting inputs.
// - Comparator high when non-inverting input exceeds inverting input.
`ifndef CVR_DEFINES_SVH
`define CVR_DEFINES_SVH

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define CVR_IDX_PORT 8'h05
`define CVR_IDX_DIR 8'h85
`define CVR_IDX_CMCFG 8'h9C
`define CVR_IDX_LADDER 8'h9D
`define CVR_IDX_ANSEL 8'h9E
`define CVR_IDX_ROUTE 8'h9F

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define CVR_CMCFG_RST 8'h07
`define CVR_CMCFG_WMASK 8'h3F
`define CVR_LADDER_RST 8'h00
`define CVR_LADDER_WMASK 8'hEF
`define CVR_DIR_RST 6'h3F
`define CVR_ANSEL_RST 6'h3F
`define CVR_PORT_RST 6'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CVR_B_RES2 7
`define CVR_B_RES1 6
`define CVR_B_INV2 5
`define CVR_B_INV1 4
`define CVR_B_PWR 7
`define CVR_B_PIN 6
`define CVR_B_RANGE 5
`define CVR_B_UNIMP 4
`define CVR_MODE_REF 3'h6
`define CVR_HTRANS_NONSEQ 2'h2

`endif

/* File: cvr_pkg.sv */
// Types shared by the comparator reference control block.
// Assumes constants come from cvr_defines.svh.
package cvr_pkg;

  // Bus slave phases
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WR,
    ST_RD,
    ST_RDY
  } cvr_bus_st_t;

endpackage : cvr_pkg

/* File: tb_top.sv */
// Self-checking bench for the comparator and reference ladder control block.
// Assumes cvr_ctrl with its AHB-Lite slave alone on the bus, hready = hreadyout.
`timescale 1ns/1ps
`include "cvr_defines.svh"

module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic cmp1_raw = 1'b0;
  logic cmp2_raw = 1'b0;
  logic [5:0] pa_in = 6'h00;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire [5:0] pa_out;
  wire [5:0] pa_oe_n;
  wire [2:0] mode;
  wire ref_sel, pwr, pin, rng;
  wire [3:0] tap;
  integer seed = 83696;
  integer error_cnt = 0;
  integer samples_checked = 0;
  integer i;
  logic [7:0] m_cfg, m_lad, m_dir, m_ans, m_prt, d;
  logic [31:0] rd;

  // ----------------------------------------
  // Clock, device under test, watchdog
  // ----------------------------------------
  always #5 mclk = ~mclk;

  cvr_ctrl i_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp1_raw(cmp1_raw),
    .cmp2_raw(cmp2_raw), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
    .comparator_mode_field(mode), .ladder_ref_sel(ref_sel), .ladder_power_on(pwr),
    .ladder_pin_drive(pin), .ladder_range_sel(rng), .ladder_tap_value(tap));

  // A run of about sixty transfers; far beyond that means a hung handshake
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    stop_test();
  end

  // ----------------------------------------
  // Bus master and comparison tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address phase held until hready seen high, then data phase likewise
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= `CVR_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {$random(seed)} & 32'hFFFFFF00 | {24'h0, wd};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
    chk({31'h0, hresp}, 32'h0);
  endtask : rd_chk

  // Comparator raw inputs move right after a clock edge
  task automatic new_raw();
    @(posedge mclk);
    cmp1_raw <= 1'($random(seed));
    cmp2_raw <= 1'($random(seed));
    pa_in <= 6'($random(seed));
    #1;
  endtask : new_raw

  // Expected readback of the config register from the model
  function automatic logic [7:0] cfg_exp();
    return {cmp2_raw ^ m_cfg[5], cmp1_raw ^ m_cfg[4], m_cfg[5:0]};
  endfunction : cfg_exp

  task automatic stop_test();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    m_cfg = 8'h07;
    m_lad = 8'h00;
    // Reset values, then an unmapped index
    chk({26'h0, pa_oe_n}, 32'h3F);
    rd_chk(`CVR_IDX_CMCFG, cfg_exp());
    rd_chk(`CVR_IDX_LADDER, 8'h00);
    rd_chk(`CVR_IDX_DIR, 8'h3F);
    rd_chk(`CVR_IDX_ANSEL, 8'h3F);
    rd_chk(`CVR_IDX_ROUTE, 8'h00);
    rd_chk(8'hA0, 8'h00);
    // Ladder control: all ones first, then random patterns
    for (i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'hFF : 8'($random(seed));
      bus(1'b1, `CVR_IDX_LADDER, d);
      m_lad = d & 8'hEF;
      chk({28'h0, pwr, pin, rng, 1'b0}, {28'h0, m_lad[7:5], 1'b0});
      chk({28'h0, tap}, {28'h0, m_lad[3:0]});
      rd_chk(`CVR_IDX_LADDER, m_lad);
    end
    // Every comparator mode, result bits written as ones, random inversion
    for (i = 0; i < 8; i++) begin
      d = {2'b11, 3'($random(seed)), 3'(i)};
      bus(1'b1, `CVR_IDX_CMCFG, d);
      m_cfg = d & 8'h3F;
      chk({29'h0, mode}, i);
      chk({31'h0, ref_sel}, (i == 6) ? 32'h1 : 32'h0);
      new_raw();
      rd_chk(`CVR_IDX_CMCFG, cfg_exp());
      chk({26'h0, tap, 2'h0}, {26'h0, m_lad[3:0], 2'h0});
    end
    // Pin routing with random direction, analog select and latch
    m_dir = 8'($random(seed)) & 8'h3F;
    m_ans = 8'($random(seed)) & 8'h3F;
    m_prt = 8'($random(seed)) & 8'h3F;
    bus(1'b1, `CVR_IDX_DIR, m_dir);
    bus(1'b1, `CVR_IDX_ANSEL, m_ans);
    bus(1'b1, `CVR_IDX_PORT, m_prt);
    chk({26'h0, pa_out}, {26'h0, m_prt[5:0]});
    bus(1'b1, `CVR_IDX_ROUTE, 8'h01);
    for (i = 0; i < 8; i++) begin
      if (i[0]) begin
        d = {2'b00, 3'($random(seed)), 3'h6};
        bus(1'b1, `CVR_IDX_CMCFG, d);
        m_cfg = d;
      end
      new_raw();
      d = {2'b00, cmp2_raw ^ m_cfg[5], cmp1_raw ^ m_cfg[4], m_prt[3:0]};
      chk({26'h0, pa_out}, {24'h0, d});
      chk({26'h0, pa_oe_n}, {26'h0, m_dir[5:0]});
      rd_chk(`CVR_IDX_PORT, {2'b00, pa_in & ~m_ans[5:0]});
    end
    bus(1'b1, `CVR_IDX_ROUTE, 8'h00);
    chk({26'h0, pa_out}, {26'h0, m_prt[5:0]});
    // Mid-run reset: every control back to its power-up value
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({26'h0, pa_oe_n}, 32'h3F);
    chk({26'h0, pa_out}, 32'h0);
    chk({24'h0, pwr, pin, rng, 1'b0, tap}, 32'h0);
    chk({29'h0, mode}, 32'h7);
    chk({31'h0, ref_sel}, 32'h0);
    rd_chk(`CVR_IDX_CMCFG, {cmp2_raw, cmp1_raw, 6'h07});
    stop_test();
  end
endmodule : tb_top
